// ---- pft_map.svh ----
`ifndef PFT_MAP_SVH
`define PFT_MAP_SVH

// byte address width of the program space
`define PFT_ADDR_W 16
// program word and data byte widths
`define PFT_WORD_W 16
`define PFT_BYTE_W 8
// block sizes in bytes
`define PFT_WRITE_BLOCK_BYTES 8
`define PFT_ERASE_BLOCK_BYTES 64
// value of an erased byte
`define PFT_ERASED_BYTE 8'hFF
// system clock rate in MHz (40 ns period)
`define PFT_MCLK_MHZ 25
// internal programming time in microseconds (plain default)
`define PFT_PROG_TIME_US 2000
// programming time in mclk cycles
`define PFT_PROG_CYCLES (`PFT_PROG_TIME_US * `PFT_MCLK_MHZ)

`endif

// ---- pft_pkg.sv ----
package pft_pkg;

  // sequencer states along idle -> write -> time -> idle, gray coded except the time -> idle step
  typedef enum logic [1:0] {
    PFT_IDLE = 2'h0,  // free for reads and table writes
    PFT_WRITE = 2'h1, // words being committed to the array
    PFT_TIME = 2'h3   // programming timer running
  } pft_state_type;

  // kind of array operation in flight
  typedef enum logic {
    PFT_OP_PROG = 1'h0,  // commit of the holding registers
    PFT_OP_ERASE = 1'h1  // block erase
  } pft_op_type;

endpackage

// ---- pft_mem.sv ----
// word array with one registered read port and one write port
module pft_mem #(
  parameter int AW = 15, // word address width
  parameter int DW = 16  // word width
) (
  input wire logic mclk,           // system clock
  input wire logic rd_en,          // read strobe
  input wire logic [AW-1:0] rd_addr, // read word address
  output logic [DW-1:0] rd_data,   // read word, one cycle after strobe
  input wire logic wr_en,          // write strobe
  input wire logic [AW-1:0] wr_addr, // write word address
  input wire logic [DW-1:0] wr_data  // write word
);

  logic [DW-1:0] array [0:(2**AW)-1]; // storage, no reset on purpose

  // write port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      array[wr_addr] <= wr_data;
    end
  end

  // registered read; a colliding write shows on the next read only
  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data <= array[rd_addr];
    end
  end

endmodule // pft_mem

// ---- pft_top.sv ----
// Behaviour
// - each table read returns exactly one byte
// - programming commits whole eight-byte blocks
// - erase clears one sixty-four-byte block
// - whole-array erase request is refused
// - write or erase stalls fetch and accesses
// - internal timer ends every write or erase
// - any data value is accepted into memory
// - sixteen-bit words, eight-bit data side
// - table bytes pass the eight-bit latch, but a table write drops a read byte due the same cycle; fetches bypass it
// - table read fetches addressed byte
// - table write fills holding registers only
// - byte addressing, no word alignment needed
`include "pft_map.svh"

module pft_top #(
  parameter int ADDR_W = `PFT_ADDR_W,                // byte address width
  parameter int unsigned PROG_CYCLES = `PFT_PROG_CYCLES // programming time in cycles
) (
  input wire logic mclk,                     // system clock
  input wire logic rst,                      // synchronous reset, active high
  input wire logic [ADDR_W-1:0] table_addr,  // byte address of table access
  input wire logic table_read_op,            // table read request pulse
  input wire logic table_write_op,           // table write request pulse
  input wire logic [7:0] table_wdata,        // byte from data space
  output logic [7:0] table_latch,            // table latch contents
  output logic table_read_done,              // latch holds read byte unless a table write took the latch, pulse
  input wire logic prog_start,               // commit holding block pulse
  input wire logic erase_start,              // block erase request pulse
  input wire logic bulk_erase_req,           // whole-array erase request pulse
  output logic bulk_refused,                 // whole-array erase refused, pulse
  output logic busy,                         // write or erase in progress
  input wire logic fetch_req,                // instruction fetch request pulse
  input wire logic [ADDR_W-2:0] fetch_addr,  // fetch word address
  output logic [15:0] fetch_word,            // fetched instruction word
  output logic fetch_valid                   // fetch_word valid, pulse
);

  localparam int WA = ADDR_W - 1; // word address width
  localparam int HB = `PFT_WRITE_BLOCK_BYTES; // holding bytes
  localparam logic [4:0] PROG_LAST = 5'((`PFT_WRITE_BLOCK_BYTES / 2) - 1);
  localparam logic [4:0] ERASE_LAST = 5'((`PFT_ERASE_BLOCK_BYTES / 2) - 1);
  localparam logic [31:0] TMR_LAST = 32'(PROG_CYCLES - 1);

  pft_pkg::pft_state_type state; // sequencer state
  pft_pkg::pft_op_type op;       // operation in flight
  logic [WA-1:0] op_base;        // first word of the block in flight
  logic [4:0] word_cnt;          // word within block
  logic [31:0] tmr;              // programming timer
  logic [7:0] hold [0:HB-1];     // holding registers
  logic rd_tbl_pend;             // table read awaiting memory data
  logic rd_fetch_pend;           // fetch awaiting memory data
  logic rd_odd;                  // high byte of word selected
  logic [15:0] mem_rdata;        // registered word from array
  logic idle;                    // free for accesses
  logic take_erase;              // erase accepted this cycle
  logic take_prog;               // program accepted this cycle
  logic take_twrite;             // table write accepted this cycle
  logic take_tread;              // table read accepted this cycle
  logic take_fetch;              // fetch accepted this cycle
  logic mem_rd_en;               // array read strobe
  logic [WA-1:0] mem_rd_addr;    // array read word address
  logic mem_wr_en;               // array write strobe
  logic [WA-1:0] mem_wr_addr;    // array write word address
  logic [15:0] mem_wdata;        // array write word

  // accept logic, fixed priority: erase, program, table write, read, fetch
  always_comb begin
    idle = (state == pft_pkg::PFT_IDLE) && !busy;
    take_erase = idle && erase_start;
    take_prog = idle && !erase_start && prog_start;
    take_twrite = idle && !erase_start && !prog_start && table_write_op;
    take_tread = idle && !erase_start && !prog_start && !table_write_op
                 && table_read_op;
    take_fetch = idle && !erase_start && !prog_start && !table_write_op
                 && !table_read_op && fetch_req;
  end

  // one shared read port: table read uses the word holding the byte
  always_comb begin
    mem_rd_en = take_tread || take_fetch;
    mem_rd_addr = take_tread ? table_addr[ADDR_W-1:1] : fetch_addr;
  end

  // array writes happen only while the sequencer walks a block
  always_comb begin
    mem_wr_en = (state == pft_pkg::PFT_WRITE);
    mem_wr_addr = op_base + WA'(word_cnt);
    if (op == pft_pkg::PFT_OP_ERASE) begin
      mem_wdata = {`PFT_ERASED_BYTE, `PFT_ERASED_BYTE};
    end else begin
      // low byte at even address; any pattern is stored as is
      mem_wdata = {hold[{word_cnt[1:0], 1'b1}], hold[{word_cnt[1:0], 1'b0}]};
    end
  end

  pft_mem #(
    .AW(WA),
    .DW(`PFT_WORD_W)
  ) u_mem (
    .mclk(mclk),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rdata),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wdata)
  );

  // sequencer: walk the block, then let the timer close the operation
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= pft_pkg::PFT_IDLE;
      op <= pft_pkg::PFT_OP_PROG;
      op_base <= '0;
      word_cnt <= 5'h00;
    end else begin
      case (state)
        pft_pkg::PFT_IDLE: begin
          word_cnt <= 5'h00;
          if (take_erase) begin
            // erase covers the aligned 64-byte block of the address
            op <= pft_pkg::PFT_OP_ERASE;
            op_base <= {table_addr[ADDR_W-1:6], 5'h00};
            state <= pft_pkg::PFT_WRITE;
          end else if (take_prog) begin
            // commit covers the aligned 8-byte block of the address
            op <= pft_pkg::PFT_OP_PROG;
            op_base <= {table_addr[ADDR_W-1:3], 2'h0};
            state <= pft_pkg::PFT_WRITE;
          end
        end
        pft_pkg::PFT_WRITE: begin
          word_cnt <= word_cnt + 5'h01;
          if ((op == pft_pkg::PFT_OP_ERASE) ? (word_cnt == ERASE_LAST)
              : (word_cnt == PROG_LAST)) begin
            state <= pft_pkg::PFT_TIME;
          end
        end
        pft_pkg::PFT_TIME: begin
          if (tmr == TMR_LAST) begin
            state <= pft_pkg::PFT_IDLE;
          end
        end
        default: begin
          state <= pft_pkg::PFT_IDLE;
        end
      endcase
    end
  end

  // programming timer, the only thing that ends a write or erase
  always_ff @(posedge mclk) begin
    if (rst) begin
      tmr <= 32'h00000000;
    end else if (state == pft_pkg::PFT_TIME) begin
      tmr <= tmr + 32'h00000001;
    end else begin
      tmr <= 32'h00000000;
    end
  end

  // busy rises with the accepted start and falls with the timer's end
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (take_erase || take_prog) begin
      busy <= 1'b1;
    end else if (state == pft_pkg::PFT_TIME && tmr == TMR_LAST) begin
      busy <= 1'b0;
    end
  end

  // whole-array erase never reaches the array from running code
  always_ff @(posedge mclk) begin
    if (rst) begin
      bulk_refused <= 1'b0;
    end else begin
      bulk_refused <= bulk_erase_req;
    end
  end

  // holding registers: table writes only load them, commit empties them
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < HB; i++) begin
        hold[i] <= `PFT_ERASED_BYTE;
      end
    end else if (take_twrite) begin
      hold[table_addr[2:0]] <= table_wdata;
    end else if (state == pft_pkg::PFT_TIME && op == pft_pkg::PFT_OP_PROG
                 && tmr == TMR_LAST) begin
      // cleared so a partly filled next block leaves other bytes erased
      for (int i = 0; i < HB; i++) begin
        hold[i] <= `PFT_ERASED_BYTE;
      end
    end
  end

  // read bookkeeping, one cycle from strobe to array data
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_tbl_pend <= 1'b0;
      rd_fetch_pend <= 1'b0;
      rd_odd <= 1'b0;
    end else begin
      rd_tbl_pend <= take_tread;
      rd_fetch_pend <= take_fetch;
      if (take_tread) begin
        rd_odd <= table_addr[0];
      end
    end
  end

  // table latch: table bytes in either direction pass through it; a table write wins over a read byte due the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      table_latch <= 8'h00;
      table_read_done <= 1'b0;
    end else begin
      table_read_done <= rd_tbl_pend;
      if (take_twrite) begin
        table_latch <= table_wdata;
      end else if (rd_tbl_pend) begin
        // only one byte of the word leaves per read
        table_latch <= rd_odd ? mem_rdata[15:8] : mem_rdata[7:0];
      end
    end
  end

  // fetch port; decoding invalid words as no-op is left to the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_word <= 16'h0000;
      fetch_valid <= 1'b0;
    end else begin
      fetch_valid <= rd_fetch_pend;
      if (rd_fetch_pend) begin
        fetch_word <= mem_rdata;
      end
    end
  end

endmodule // pft_top

// ---- pft_properties.sv ----
// port checker for the table access sequencer
module pft_properties #(
  parameter int unsigned PROG_CYCLES = 8 // timer length
) (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic table_read_op, // read req
  input wire logic table_write_op, // write req
  input wire logic [7:0] table_wdata, // write byte
  input wire logic [7:0] table_latch, // latch
  input wire logic table_read_done, // read pulse
  input wire logic prog_start, // commit req
  input wire logic erase_start, // erase req
  input wire logic bulk_erase_req, // bulk req
  input wire logic bulk_refused, // refusal pulse
  input wire logic busy, // busy level
  input wire logic fetch_req, // fetch req
  input wire logic fetch_valid // fetch pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // busy spans, less one: word writes then the timer
  localparam int PH = PROG_CYCLES + 3;
  localparam int EH = PROG_CYCLES + 31;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // no commit or erase wins priority over a lesser request
  logic free;
  assign free = !busy && !erase_start && !prog_start;
  a_read_latency: assert property (free && !table_write_op && table_read_op
    |-> ##2 table_read_done) else $error("read answer late or missing");
  a_read_cause: assert property (table_read_done
    |-> $past(table_read_op, 2) && !$past(busy, 2)) else $error("read pulse without a read");
  a_stall_access: assert property (busy && (table_read_op || fetch_req)
    |-> ##2 !(table_read_done || fetch_valid)) else $error("access served while busy");
  a_fetch_latency: assert property (free && !table_write_op && !table_read_op
    && fetch_req |-> ##2 fetch_valid) else $error("fetch answer late or missing");
  a_latch_write: assert property (free && table_write_op
    |=> table_latch == $past(table_wdata)) else $error("latch missed written byte");
  a_bulk_refuse: assert property (bulk_refused == $past(bulk_erase_req))
    else $error("bulk erase not refused");
  a_prog_span: assert property (!busy && !erase_start && prog_start
    |=> (busy throughout (1'b1 ##PH 1'b1)) ##1 !busy) else $error("commit busy span wrong");
  a_erase_span: assert property (!busy && erase_start
    |=> (busy throughout (1'b1 ##EH 1'b1)) ##1 !busy) else $error("erase busy span wrong");
  a_busy_cause: assert property ($rose(busy) |-> $past(prog_start || erase_start))
    else $error("busy rose without a start");
endmodule // pft_properties

bind pft_top pft_properties #(.PROG_CYCLES(PROG_CYCLES)) chk (.*);

// ---- pft_core_model.sv ----
// processor core fetch side: issues word fetches on command
module pft_core_model #(
  parameter int AW = 7 // word address width
) (
  input wire logic mclk, // clock
  input wire logic go, // issue a fetch
  input wire logic [AW-1:0] word, // word to fetch
  output logic fetch_req, // fetch pulse
  output logic [AW-1:0] fetch_addr // word address
);
  timeunit 1ns;
  timeprecision 1ns;
  // whole-word addresses only, so fetched code is always aligned
  // one process drives both outputs; the idle address is the inverse of word, never stale
  always @(posedge mclk) begin
    fetch_req <= go;
    fetch_addr <= go ? word : ~word;
  end
endmodule // pft_core_model

// ---- program_flash_table_access_tb.sv ----
module program_flash_table_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 8; // shortened programming timer
  logic mclk = 1'b0, rst = 1'b1, go = 1'b0, busy, bulk_refused;
  logic table_read_op = 1'b0, table_write_op = 1'b0, prog_start = 1'b0;
  logic erase_start = 1'b0, bulk_erase_req = 1'b0, table_read_done, fetch_req, fetch_valid;
  logic [7:0] table_addr = 8'h00, table_wdata = 8'h00, table_latch;
  logic [6:0] word = 7'h00, fetch_addr;
  logic [15:0] fetch_word;
  logic [15:0] exp_q[$]; // expected read and fetch results in order
  logic [7:0] d[8]; // random bytes of the committed block
  logic [31:0] seed;
  int err_count = 0, checked = 0;
  pft_top #(.ADDR_W(8), .PROG_CYCLES(PC)) uut (.*);
  pft_core_model core (.*);
  always #20 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one cycle of requests: 0 read, 1 write, 2 commit, 3 erase, 4 bulk, 6 fetch, else idle
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] w);
    table_addr <= a;
    table_wdata <= w;
    word <= a[6:0];
    table_read_op <= (k == 0);
    table_write_op <= (k == 1);
    prog_start <= (k == 2);
    erase_start <= (k == 3);
    bulk_erase_req <= (k == 4);
    go <= (k == 6);
    @(posedge mclk);
  endtask
  // bounded wait for the programming timer to let go
  task automatic wait_idle;
    op(5, 8'h00, 8'h00);
    @(negedge mclk);
    repeat (60) if (busy === 1'b1) @(negedge mclk);
    check("busy", {15'h0, busy}, 16'h0000);
    @(posedge mclk);
  endtask
  // scoreboard: each read or fetch pulse takes the oldest note
  always @(negedge mclk) begin
    if (table_read_done === 1'b1 || fetch_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected pulse", 16'h0001, 16'h0000);
      end else if (fetch_valid === 1'b1) begin
        check("fetch_word", fetch_word, exp_q.pop_front());
      end else begin
        check("table_latch", {8'h00, table_latch}, exp_q.pop_front());
      end
    end
  end
  initial begin
    seed = 32'h9853;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    op(3, 8'h05, 8'h00); // erase the first block from an inner byte
    wait_idle();
    // random bytes into the holding block at bytes 8..15
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d[i] = seed[7:0];
      op(1, 8'd8 + i[7:0], seed[7:0]);
    end
    op(2, 8'h0B, 8'h00); // commit, address aligns down to 8
    op(0, 8'h08, 8'h00); // refused while busy
    op(6, 8'h04, 8'h00); // fetch refused while busy
    op(4, 8'h00, 8'h00); // bulk erase, refused and harmless
    wait_idle();
    // back-to-back byte reads from an odd address
    for (int i = 1; i < 8; i++) begin
      exp_q.push_back({8'h00, d[i]});
      op(0, 8'd8 + i[7:0], 8'h00);
    end
    // every word of the erased block, the committed four among them
    for (int i = 0; i < 32; i++) begin
      exp_q.push_back(i >= 4 && i < 8 ? {d[2*i-7], d[2*i-8]} : 16'hFFFF);
      op(6, i[7:0], 8'h00);
    end
    repeat (4) op(5, 8'h00, 8'h00);
    check("pending", 16'(exp_q.size()), 16'h0000);
    stop_test();
  end
  // hang guard: the sequence needs well under 400 cycles
  initial begin
    #(2000 * 40);
    err_count++;
    stop_test();
  end
endmodule // program_flash_table_access_tb
